// >>> rfch_defines.svh
// Purpose: constants of the fast command handler
// Assumes: included by bare name
// Notes:   offsets are byte addresses on the register port
`ifndef RFCH_DEFINES_SVH
`define RFCH_DEFINES_SVH

`define RFCH_CMD_FINV    8'hC1
`define RFCH_CMD_FINIT   8'hC2
`define RFCH_CMD_FRMB    8'hC3

`define RFCH_FLG_SUBC    0
`define RFCH_FLG_INV     2
`define RFCH_FLG_PEXT    3
`define RFCH_FLG_SEL     4
`define RFCH_FLG_ADDR    5
`define RFCH_FLG_AFI     4
`define RFCH_FLG_NBS     5
`define RFCH_FLG_OPT     6

`define RFCH_RSP_OK      8'h00
`define RFCH_RSP_ERR     8'h01
`define RFCH_ERR_OPT     8'h03
`define RFCH_ERR_GEN     8'h0F
`define RFCH_ERR_ADDR    8'h10
`define RFCH_ERR_RPROT   8'h15

`define RFCH_CRC_INIT    16'hFFFF
`define RFCH_CRC_POLY    16'h8408
`define RFCH_CRC_GOOD    16'hF0B8

`define RFCH_CNT_MAX     8'h1F
`define RFCH_SECT_LSB    5
`define RFCH_SS_MASK     8'h1F
`define RFCH_MLEN_1SLOT  8'h40
`define RFCH_MLEN_16SLOT 8'h3C

`define RFCH_REG_CTRL    8'h00
`define RFCH_REG_DSFID   8'h04
`define RFCH_REG_AFI     8'h08
`define RFCH_REG_UID_LO  8'h0C
`define RFCH_REG_UID_HI  8'h10
`define RFCH_REG_STATUS  8'h14

`define RFCH_CTRL_RST    1'b1

`endif

// >>> rfch_pkg.sv
// Purpose: types of the fast command handler
// Assumes: nothing
// Notes:   carriers for the modem receive and transmit sides
package rfch_pkg;

  typedef enum logic [2:0] {
    S_IDLE, S_RX, S_SLOT, S_LOOK, S_FETCH, S_SEND, S_DONE
  } rfch_state_t;

  typedef enum logic [3:0] {
    P_FLAGS, P_CMD, P_MFG, P_AFI, P_MLEN, P_MASK, P_UID, P_FIRST, P_CNT, P_TAIL
  } rfch_phase_t;

  typedef enum logic [1:0] {
    K_ID, K_READ, K_ERR
  } rfch_kind_t;

  typedef struct packed {
    logic       sof;
    logic       eof;
    logic       vld;
    logic [7:0] data;
  } rfch_rx_t;

  typedef struct packed {
    logic       sof;
    logic       vld;
    logic [7:0] data;
    logic       last;
    logic       fast;
  } rfch_tx_t;

endpackage : rfch_pkg

// >>> rfch_crc16.sv
// Purpose: bytewise frame crc, reflected, preset to all ones
// Assumes: one byte per cycle at most
// Notes:   init with vld folds the first byte into the preset
`timescale 1ns/100ps
`include "rfch_defines.svh"
module rfch_crc16 (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire logic        init,
  input  wire logic        vld,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);

  typedef struct packed {
    logic [15:0] crc;
  } rfch_crc_st_t;

  rfch_crc_st_t s_q;
  rfch_crc_st_t s_d;

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ `RFCH_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  always_comb begin
    s_d = s_q;
    if (init) begin
      s_d.crc = vld ? crc_byte(`RFCH_CRC_INIT, data) : `RFCH_CRC_INIT;
    end else if (vld) begin
      s_d.crc = crc_byte(s_q.crc, data);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign crc = s_q.crc;

endmodule : rfch_crc16

// >>> rfch_fast_cmd.sv
// Purpose: tag-side handler of the three double-rate commands
// Assumes: modem, memory and sector lookup run on mclk
// Notes:   sector lookup answers combinationally on mem_addr
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/100ps
`include "rfch_defines.svh"
// Behaviour
// R1 - inventory needs initiate flag
// R2 - subcarrier flag set is refused
// R3 - inventory flag required, anticollision slots
// R4 - responses at double rate
// R5 - inventory request fields in order
// R6 - inventory errors give no reply
// R7 - identity reply: flags, dsfid, uid, crc
// R8 - reader waits before slot marker
// R9 - reader wait depends on modulation
// R10 - busy until reply or power-off
// R11 - write mode releases status pin
// R12 - initiate sets flag, non-addressed only
// R13 - power loss clears initiate flag
// R14 - initiate request: flags, code, maker
// R15 - busy from request to response end
// R16 - read count field is minus one
// R17 - at most 32 blocks, one sector
// R18 - extension flag required, option honoured
// R19 - read request: flags, code, uid, range
// R20 - read reply: flags, status, words, crc
// R21 - status upper bits read zero
// R22 - read errors 03h, 10h, 15h
// R23 - error frames set error flag
module rfch_fast_cmd #(
  parameter int unsigned NUM_BLOCKS = 2048,
  parameter logic [7:0]  MAKER_CODE = 8'h5A  // arbitrary value
) (
  input  wire logic              mclk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire rfch_pkg::rfch_rx_t rx,
  input  wire logic              slot_mark,
  input  wire logic              rf_power_off,
  input  wire logic              tag_ready,
  input  wire logic              tag_selected,
  output rfch_pkg::rfch_tx_t     tx,
  input  wire logic              tx_ready,
  input  wire logic              tx_done,
  output logic                   mem_req,
  output logic      [15:0]       mem_addr,
  input  wire logic [31:0]       mem_rdata,
  input  wire logic              mem_rvalid,
  input  wire logic [7:0]        sec_status,
  input  wire logic              sec_rlock,
  output logic                   rf_status_output,
  output logic                   rf_status_oe
);

  typedef struct packed {
    rfch_pkg::rfch_state_t state;
    rfch_pkg::rfch_phase_t phase;
    rfch_pkg::rfch_kind_t  kind;
    logic [7:0]            flags;
    logic [7:0]            cmd;
    logic                  bad;
    logic                  mism;
    logic                  afi_ok;
    logic [3:0]            k;
    logic [7:0]            mlen;
    logic [15:0]           first;
    logic [7:0]            cnt;
    logic [3:0]            slot;
    logic [3:0]            myslot;
    logic                  init_flag;
    logic                  busy;
    logic [7:0]            err;
    logic [3:0]            pos;
    logic [4:0]            blk;
    logic                  hdr;
    logic                  crcb;
    logic [31:0]           word;
    logic                  status_busy_mode;
    logic [7:0]            dsfid;
    logic [7:0]            afi;
    logic [63:0]           uid;
    logic [7:0]            last_err;
    logic [31:0]           rdata;
    rfch_pkg::rfch_tx_t    tx;
    logic                  mem_req;
    logic [15:0]           mem_addr;
    logic                  pin_lvl;
    logic                  oe;
  } rfch_st_t;

  rfch_st_t s_q;
  rfch_st_t s_d;

  logic                 rst_meta_q;
  logic                 rst_n_q;
  logic [15:0]          rxc_crc;
  logic [15:0]          txc_crc;
  logic                 feed;
  logic                 txi;
  logic                 go;
  rfch_pkg::rfch_kind_t go_kind;
  logic [7:0]           go_err;
  logic [16:0]          lastb;
  logic                 ok_frame;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  function automatic logic [7:0] uid_byte(input logic [63:0] u, input logic [3:0] i);
    return (i < 4'h8) ? u[{i[2:0], 3'b000} +: 8] : 8'h00;
  endfunction : uid_byte

  function automatic logic [7:0] mask_bits(input logic [7:0] len, input logic [3:0] i);
    logic [8:0] rem;
    rem = {1'b0, len} - {2'b00, i, 3'b000};
    return (rem >= 9'h008) ? 8'hFF : 8'((9'h001 << rem) - 9'h001);
  endfunction : mask_bits

  function automatic logic [7:0] blk_byte(input logic [3:0] p, input logic [31:0] w, input logic [7:0] ss);
    logic [3:0] q;
    q = p - 4'h1;
    return (p == 4'h0) ? (ss & `RFCH_SS_MASK) : w[{q[1:0], 3'b000} +: 8];  // R21
  endfunction : blk_byte

  always_comb begin
    s_d         = s_q;
    feed        = 1'b0;
    txi         = 1'b0;
    go          = 1'b0;
    go_kind     = rfch_pkg::K_ID;
    go_err      = `RFCH_RSP_OK;
    lastb       = {1'b0, s_q.first} + {9'h000, s_q.cnt};
    ok_frame    = 1'b0;
    s_d.mem_req = 1'b0;
    s_d.pin_lvl = 1'b0;
    s_d.rdata   = '0;

    if (reg_wr) begin
      unique case (reg_addr)
        `RFCH_REG_CTRL:   s_d.status_busy_mode = reg_wdata[0];
        `RFCH_REG_DSFID:  s_d.dsfid = reg_wdata[7:0];
        `RFCH_REG_AFI:    s_d.afi = reg_wdata[7:0];
        `RFCH_REG_UID_LO: s_d.uid[31:0] = reg_wdata;
        `RFCH_REG_UID_HI: s_d.uid[63:32] = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        `RFCH_REG_CTRL:   s_d.rdata = {31'h0, s_q.status_busy_mode};
        `RFCH_REG_DSFID:  s_d.rdata = {24'h0, s_q.dsfid};
        `RFCH_REG_AFI:    s_d.rdata = {24'h0, s_q.afi};
        `RFCH_REG_UID_LO: s_d.rdata = s_q.uid[31:0];
        `RFCH_REG_UID_HI: s_d.rdata = s_q.uid[63:32];
        `RFCH_REG_STATUS: s_d.rdata = {16'h0, s_q.last_err, 3'h0, s_q.state, s_q.busy, s_q.init_flag};
        default: ;
      endcase
    end

    if (rx.sof && s_q.state inside {rfch_pkg::S_IDLE, rfch_pkg::S_RX, rfch_pkg::S_SLOT}) begin
      s_d.state  = rfch_pkg::S_RX;
      s_d.phase  = rfch_pkg::P_FLAGS;
      s_d.bad    = 1'b0;
      s_d.mism   = 1'b0;
      s_d.afi_ok = 1'b0;
      s_d.k      = 4'h0;
      s_d.busy   = 1'b1;  // R10 R15
    end else if (rx.vld && s_q.state == rfch_pkg::S_RX) begin
      unique case (s_q.phase)
        rfch_pkg::P_FLAGS: begin
          s_d.flags = rx.data;
          s_d.phase = rfch_pkg::P_CMD;
        end
        rfch_pkg::P_CMD: begin
          s_d.cmd   = rx.data;
          s_d.phase = rfch_pkg::P_MFG;
          if (rx.data != `RFCH_CMD_FINV && rx.data != `RFCH_CMD_FINIT && rx.data != `RFCH_CMD_FRMB) begin
            s_d.bad = 1'b1;
          end
        end
        rfch_pkg::P_MFG: begin  // R5 R14 R19
          s_d.k = 4'h0;
          if (rx.data != MAKER_CODE) begin
            s_d.bad = 1'b1;
          end
          if (s_q.cmd == `RFCH_CMD_FINV) begin
            s_d.phase = s_q.flags[`RFCH_FLG_AFI] ? rfch_pkg::P_AFI : rfch_pkg::P_MLEN;
          end else if (s_q.cmd == `RFCH_CMD_FRMB) begin
            s_d.phase = s_q.flags[`RFCH_FLG_ADDR] ? rfch_pkg::P_UID : rfch_pkg::P_FIRST;
          end else begin
            s_d.phase = rfch_pkg::P_TAIL;
          end
        end
        rfch_pkg::P_AFI: begin
          s_d.afi_ok = (rx.data == s_q.afi) || (rx.data == 8'h00);
          s_d.phase  = rfch_pkg::P_MLEN;
        end
        rfch_pkg::P_MLEN: begin
          s_d.mlen  = rx.data;
          s_d.phase = (rx.data == 8'h00) ? rfch_pkg::P_TAIL : rfch_pkg::P_MASK;
        end
        rfch_pkg::P_MASK: begin  // R5
          if (|((rx.data ^ uid_byte(s_q.uid, s_q.k)) & mask_bits(s_q.mlen, s_q.k))) begin
            s_d.mism = 1'b1;
          end
          s_d.k = s_q.k + 4'h1;
          if ({s_q.k + 4'h1, 3'b000} >= {3'b000, s_q.mlen} || s_q.k == 4'h7) begin
            s_d.phase = rfch_pkg::P_TAIL;
            s_d.k     = 4'h0;
          end
        end
        rfch_pkg::P_UID: begin  // R19
          if (rx.data != uid_byte(s_q.uid, s_q.k)) begin
            s_d.mism = 1'b1;
          end
          s_d.k = s_q.k + 4'h1;
          if (s_q.k == 4'h7) begin
            s_d.phase = rfch_pkg::P_FIRST;
            s_d.k     = 4'h0;
          end
        end
        rfch_pkg::P_FIRST: begin
          if (s_q.k == 4'h0) begin
            s_d.first[7:0] = rx.data;
            s_d.k          = 4'h1;
          end else begin
            s_d.first[15:8] = rx.data;
            s_d.phase       = rfch_pkg::P_CNT;
          end
        end
        rfch_pkg::P_CNT: begin
          s_d.cnt   = rx.data;
          s_d.phase = rfch_pkg::P_TAIL;
          s_d.k     = 4'h0;
        end
        rfch_pkg::P_TAIL: begin
          if (s_q.k != 4'hF) begin
            s_d.k = s_q.k + 4'h1;
          end
        end
      endcase
    end else if (rx.eof && s_q.state == rfch_pkg::S_RX) begin
      ok_frame  = (rxc_crc == `RFCH_CRC_GOOD) && (s_q.phase == rfch_pkg::P_TAIL) && (s_q.k == 4'h2) && !s_q.bad;
      s_d.state = rfch_pkg::S_IDLE;
      s_d.busy  = 1'b0;
      if (ok_frame && s_q.cmd == `RFCH_CMD_FINV) begin
        if (s_q.init_flag && s_q.flags[`RFCH_FLG_INV] && !s_q.flags[`RFCH_FLG_SUBC]      // R1 R3 R6
            && (!s_q.flags[`RFCH_FLG_AFI] || s_q.afi_ok) && !s_q.mism
            && s_q.mlen <= (s_q.flags[`RFCH_FLG_NBS] ? `RFCH_MLEN_1SLOT : `RFCH_MLEN_16SLOT)) begin
          s_d.myslot = s_q.flags[`RFCH_FLG_NBS] ? 4'h0 : 4'(s_q.uid >> s_q.mlen);  // R3
          s_d.slot   = 4'h0;
          s_d.busy   = 1'b1;  // R10
          if (s_d.myslot == 4'h0) begin
            go = 1'b1;
          end else begin
            s_d.state = rfch_pkg::S_SLOT;
          end
        end
      end else if (ok_frame && s_q.cmd == `RFCH_CMD_FINIT) begin
        if (!s_q.flags[`RFCH_FLG_SEL] && !s_q.flags[`RFCH_FLG_ADDR]                       // R12
            && !s_q.flags[`RFCH_FLG_SUBC] && !s_q.flags[`RFCH_FLG_INV]) begin
          s_d.init_flag = 1'b1;  // R12
          if (tag_ready) begin
            go       = 1'b1;  // R12
            s_d.busy = 1'b1;
          end
        end
      end else if (ok_frame && s_q.cmd == `RFCH_CMD_FRMB) begin
        if (!(s_q.flags[`RFCH_FLG_ADDR] && s_q.mism) && !(s_q.flags[`RFCH_FLG_SEL] && !tag_selected)) begin
          s_d.busy = 1'b1;
          go_kind  = rfch_pkg::K_ERR;
          go       = 1'b1;
          if (s_q.flags[`RFCH_FLG_SUBC]) begin
            go_err = `RFCH_ERR_GEN;  // R2
          end else if (!s_q.flags[`RFCH_FLG_PEXT]) begin
            go_err = `RFCH_ERR_GEN;  // R18
          end else if (s_q.flags[`RFCH_FLG_INV]) begin
            go_err = `RFCH_ERR_OPT;  // R22
          end else if (s_q.cnt > `RFCH_CNT_MAX || lastb >= 17'(NUM_BLOCKS)                  // R17
                       || lastb[15:`RFCH_SECT_LSB] != s_q.first[15:`RFCH_SECT_LSB] || lastb[16]) begin
            go_err = `RFCH_ERR_ADDR;  // R22
          end else begin
            go           = 1'b0;
            s_d.state    = rfch_pkg::S_LOOK;
            s_d.mem_addr = s_q.first;
          end
        end
      end
    end

    unique case (s_q.state)
      rfch_pkg::S_IDLE, rfch_pkg::S_RX: ;
      rfch_pkg::S_SLOT: begin
        if (slot_mark && !rx.sof) begin
          s_d.slot = s_q.slot + 4'h1;
          if (s_q.slot + 4'h1 == s_q.myslot) begin
            go = 1'b1;  // R3
          end
        end
      end
      rfch_pkg::S_LOOK: begin
        s_d.hdr = 1'b1;
        s_d.blk = 5'h00;
        if (sec_rlock) begin
          go      = 1'b1;
          go_kind = rfch_pkg::K_ERR;
          go_err  = `RFCH_ERR_RPROT;  // R22
        end else begin
          s_d.state   = rfch_pkg::S_FETCH;
          s_d.mem_req = 1'b1;
        end
      end
      rfch_pkg::S_FETCH: begin
        if (mem_rvalid) begin
          s_d.word = mem_rdata;
          if (s_q.hdr) begin
            go      = 1'b1;
            go_kind = rfch_pkg::K_READ;
          end else begin
            s_d.state   = rfch_pkg::S_SEND;
            s_d.pos     = s_q.flags[`RFCH_FLG_OPT] ? 4'h0 : 4'h1;  // R18 R20
            s_d.tx.vld  = 1'b1;
            s_d.tx.data = blk_byte(s_d.pos, mem_rdata, sec_status);
            feed        = 1'b1;
          end
        end
      end
      rfch_pkg::S_SEND: begin
        if (s_q.tx.vld && tx_ready) begin
          s_d.tx.sof = 1'b0;
          if (s_q.tx.last) begin
            s_d.tx.vld  = 1'b0;
            s_d.tx.last = 1'b0;
            s_d.state   = rfch_pkg::S_DONE;
          end else if (s_q.crcb) begin
            s_d.tx.data = ~txc_crc[15:8];
            s_d.tx.last = 1'b1;
          end else begin
            unique case (s_q.kind)
              rfch_pkg::K_ID: begin  // R7
                if (s_q.pos == 4'h9) begin
                  s_d.crcb    = 1'b1;
                  s_d.tx.data = ~txc_crc[7:0];
                end else begin
                  s_d.pos     = s_q.pos + 4'h1;
                  s_d.tx.data = (s_q.pos == 4'h0) ? s_q.dsfid : uid_byte(s_q.uid, s_q.pos - 4'h1);
                  feed        = 1'b1;
                end
              end
              rfch_pkg::K_ERR: begin  // R22
                if (s_q.pos == 4'h0) begin
                  s_d.pos     = 4'h1;
                  s_d.tx.data = s_q.err;
                  feed        = 1'b1;
                end else begin
                  s_d.crcb    = 1'b1;
                  s_d.tx.data = ~txc_crc[7:0];
                end
              end
              rfch_pkg::K_READ: begin  // R16 R20
                if (s_q.hdr) begin
                  s_d.hdr     = 1'b0;
                  s_d.pos     = s_q.flags[`RFCH_FLG_OPT] ? 4'h0 : 4'h1;
                  s_d.tx.data = blk_byte(s_d.pos, s_q.word, sec_status);
                  feed        = 1'b1;
                end else if (s_q.pos == 4'h4) begin
                  if (s_q.blk == s_q.cnt[4:0]) begin
                    s_d.crcb    = 1'b1;
                    s_d.tx.data = ~txc_crc[7:0];
                  end else begin
                    s_d.blk      = s_q.blk + 5'h01;
                    s_d.mem_addr = s_q.mem_addr + 16'h0001;
                    s_d.mem_req  = 1'b1;
                    s_d.tx.vld   = 1'b0;
                    s_d.state    = rfch_pkg::S_FETCH;
                  end
                end else begin
                  s_d.pos     = s_q.pos + 4'h1;
                  s_d.tx.data = blk_byte(s_q.pos + 4'h1, s_q.word, sec_status);
                  feed        = 1'b1;
                end
              end
              default: ;
            endcase
          end
        end
      end
      rfch_pkg::S_DONE: begin
        if (tx_done) begin
          s_d.state = rfch_pkg::S_IDLE;
          s_d.busy  = 1'b0;  // R10 R15
        end
      end
    endcase

    if (go) begin
      s_d.state   = rfch_pkg::S_SEND;
      s_d.kind    = go_kind;
      s_d.err     = go_err;
      s_d.pos     = 4'h0;
      s_d.crcb    = 1'b0;
      s_d.tx.sof  = 1'b1;
      s_d.tx.vld  = 1'b1;
      s_d.tx.last = 1'b0;
      s_d.tx.fast = 1'b1;  // R4
      s_d.tx.data = (go_kind == rfch_pkg::K_ERR) ? `RFCH_RSP_ERR : `RFCH_RSP_OK;  // R23
      feed        = 1'b1;
      txi         = 1'b1;
      if (go_kind == rfch_pkg::K_ERR) begin
        s_d.last_err = go_err;
      end
    end

    if (rf_power_off) begin
      s_d.state     = rfch_pkg::S_IDLE;
      s_d.init_flag = 1'b0;  // R13
      s_d.busy      = 1'b0;  // R10
      s_d.tx        = '0;
      s_d.mem_req   = 1'b0;
      feed          = 1'b0;
      txi           = 1'b0;
    end

    s_d.oe = s_d.busy & s_d.status_busy_mode;  // R10 R11 R15
  end

  always_ff @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q                  <= '0;
      s_q.status_busy_mode <= `RFCH_CTRL_RST;
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  rfch_crc16 u_rx_crc (
    .clk   (mclk),
    .rst_n (rst_n_q),
    .ce    (ce),
    .init  (rx.sof),
    .vld   (rx.vld),
    .data  (rx.data),
    .crc   (rxc_crc)
  );

  rfch_crc16 u_tx_crc (
    .clk   (mclk),
    .rst_n (rst_n_q),
    .ce    (ce),
    .init  (txi),
    .vld   (feed),
    .data  (s_d.tx.data),
    .crc   (txc_crc)
  );

  assign reg_rdata        = s_q.rdata;
  assign tx               = s_q.tx;
  assign mem_req          = s_q.mem_req;
  assign mem_addr         = s_q.mem_addr;
  assign rf_status_output = s_q.pin_lvl;
  assign rf_status_oe     = s_q.oe;

endmodule : rfch_fast_cmd

// >>> rfch_fast_cmd_checker.sv
// Purpose: port checks of the fast command handler
// Assumes: bound into every rfch_fast_cmd
// Notes:   pin mode tracked from register writes
`timescale 1ns/100ps
module rfch_fast_cmd_checker (
  input wire logic               mclk,
  input wire logic               arst_n,
  input wire logic [7:0]         reg_addr,
  input wire logic [31:0]        reg_wdata,
  input wire logic               reg_wr,
  input wire rfch_pkg::rfch_rx_t rx,
  input wire rfch_pkg::rfch_tx_t tx,
  input wire logic               tx_ready,
  input wire logic               tx_done,
  input wire logic               rf_power_off,
  input wire logic               rf_status_output,
  input wire logic               rf_status_oe
);
  logic       mode_q;
  logic       err_q;
  logic [3:0] idx_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= 1'b1;
      err_q  <= 1'b0;
      idx_q  <= 4'h0;
    end else begin
      if (reg_wr && reg_addr == 8'h00) mode_q <= reg_wdata[0];
      if (tx.vld && tx_ready) begin
        idx_q <= tx.sof ? 4'h1 : idx_q + 4'h1;
        err_q <= tx.sof ? tx.data == 8'h01 : err_q;
      end
    end
  end
  sequence s_err_head; tx.vld && tx_ready && tx.sof && tx.data == 8'h01; endsequence
  sequence s_err_code; tx.vld && !tx.sof && err_q && idx_q == 4'h1; endsequence
  a_fast_rate: assert property (tx.vld |-> tx.fast) else $error("slow reply");
  a_pin_level: assert property (!rf_status_output) else $error("pin high");
  a_busy_start: assert property ($rose(rf_status_oe) |-> $past(rx.sof)) else $error("busy no sof");
  a_write_free: assert property (!mode_q && !$past(mode_q) |-> !rf_status_oe) else $error("pin driven");
  a_busy_hold: assert property (rf_status_oe && !rx.eof && !tx_done && !rf_power_off |=> rf_status_oe)
    else $error("busy early");
  a_busy_end: assert property (tx_done |=> !rf_status_oe) else $error("busy late");
  a_tx_hold: assert property (tx.vld && !tx_ready |=> tx.vld && $stable(tx.data)) else $error("byte lost");
  a_err_code: assert property (s_err_code |-> tx.data inside {8'h03, 8'h0F, 8'h10, 8'h15})
    else $error("bad code");
  a_err_len: assert property (tx.vld && tx.last && err_q |-> idx_q == 4'h3) else $error("error length");
  a_err_next: assert property (s_err_head |=> tx.vld && !tx.sof) else $error("no code");
endmodule : rfch_fast_cmd_checker
bind rfch_fast_cmd rfch_fast_cmd_checker rfch_fast_cmd_checker_inst (.*);

// >>> rfch_reader_model.sv
// Purpose: reader and modem stand-in
// Assumes: one request at a time, crc added here
// Notes:   takes reply bytes with random stalls
`timescale 1ns/100ps
module rfch_reader_model (
  input  wire logic               mclk,
  input  wire rfch_pkg::rfch_tx_t tx,
  output rfch_pkg::rfch_rx_t      rx,
  output logic                    tx_ready,
  output logic                    tx_done
);
  initial {rx, tx_ready, tx_done} = '0;
  always @(posedge mclk) begin
    tx_ready <= ($urandom % 4) != 0;
    tx_done <= tx.vld && tx_ready && tx.last;
  end
  function automatic logic [15:0] crc(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return ~c;
  endfunction : crc
  task automatic send(input logic [7:0] r[$]);
    logic [15:0] c;
    c = crc(r);
    r = {r, c[7:0], c[15:8]};
    @(posedge mclk) rx.sof <= 1'b1;
    foreach (r[i]) @(posedge mclk) rx <= '{1'b0, 1'b0, 1'b1, r[i]};
    @(posedge mclk) rx <= '{1'b0, 1'b1, 1'b0, ~rx.data};
    @(posedge mclk) rx.eof <= 1'b0;
  endtask : send
endmodule : rfch_reader_model

// >>> test_rf_fast_command_handler.sv
// Purpose: self-checking bench of the fast command handler
// Assumes: reader model frames requests
// Notes:   block data is address and its inverse
`timescale 1ns/100ps
module test_rf_fast_command_handler;
  logic        mclk, arst_n, reg_wr, reg_rd, tx_ready, tx_done, mem_req, mem_rvalid, rd_d, slot_mark;
  logic        sec_rlock, rf_power_off, tag_ready, rf_status_output, rf_status_oe;
  logic [7:0]  reg_addr, sec_status, dsf, id[$], nil[$], e[$];
  logic [7:0]  iv[$] = '{8'h26, 8'hC1, 8'h5A, 8'h00};
  logic [7:0]  fl[6] = '{8'h02, 8'h0B, 8'h0E, 8'h0A, 8'h0A, 8'h0A};
  logic [7:0]  fb[6] = '{8'h00, 8'h00, 8'h00, 8'h1F, 8'h00, 8'h00};
  logic [7:0]  ct[6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h20, 8'h00};
  logic [7:0]  ec[6] = '{8'h0F, 8'h0F, 8'h03, 8'h10, 8'h10, 8'h15};
  logic [8:0]  q[$];
  logic [15:0] mem_addr, f, b;
  logic [31:0] reg_wdata, reg_rdata, mem_rdata, rq[$];
  logic [63:0] uid;
  int          fails, total_checks;
  rfch_pkg::rfch_rx_t rx;
  rfch_pkg::rfch_tx_t tx;
  rfch_fast_cmd rfch_fast_cmd_inst (.mclk(mclk), .arst_n(arst_n), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx(rx),
    .slot_mark(slot_mark), .rf_power_off(rf_power_off), .tag_ready(tag_ready), .tag_selected(1'b0),
    .tx(tx), .tx_ready(tx_ready), .tx_done(tx_done), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .sec_status(sec_status), .sec_rlock(sec_rlock),
    .rf_status_output(rf_status_output), .rf_status_oe(rf_status_oe));
  rfch_reader_model rfch_reader_model_inst (.mclk(mclk), .tx(tx), .rx(rx), .tx_ready(tx_ready),
    .tx_done(tx_done));
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d fails %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  always @(posedge mclk) begin
    if (tx.vld && tx_ready) check("tx", {23'h0, tx.data}, q.size() ? {23'h0, q.pop_front()} : 32'h1FF);
    if (rd_d) check("reg", reg_rdata, rq.size() ? rq.pop_front() : 32'hX);
    rd_d <= reg_rd;
    mem_rvalid <= mem_req;
    mem_rdata <= {mem_addr, ~mem_addr};
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk) reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back(x);
    @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk) reg_rd <= 1'b0;
  endtask : rd
  task automatic go(input logic [7:0] r[$], input logic [7:0] x[$]);
    logic [15:0] c;
    int n;
    if (x.size()) begin
      c = rfch_reader_model_inst.crc(x);
      x = {x, c[7:0], c[15:8]};
    end
    foreach (x[i]) q.push_back({1'b0, x[i]});
    rfch_reader_model_inst.send(r);
    n = 0;
    while ((q.size() || rf_status_oe || tx.vld) && n < 2000) begin
      @(posedge mclk);
      n++;
      slot_mark <= n % 40 == 0 && !tx.vld;
    end
    if (n < 2000) repeat (3) @(posedge mclk) slot_mark <= 1'b0;
    else begin
      fails++;
      summarize();
    end
  endtask : go
  initial begin
    {arst_n, reg_wr, reg_rd, reg_addr, reg_wdata, rf_power_off, tag_ready, sec_rlock, rd_d, slot_mark} = '0;
    {mem_rvalid, mem_rdata, fails, total_checks} = '0;
    void'($urandom(11871));
    uid = {$urandom, $urandom};
    dsf = 8'($urandom);
    sec_status = 8'($urandom) | 8'hE0;
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(8'h00, 32'h1);
    wr(8'h04, {24'h0, dsf});
    wr(8'h0C, uid[31:0]);
    wr(8'h10, uid[63:32]);
    rd(8'h04, {24'h0, dsf});
    rd(8'h40, 32'h0);
    id = '{8'h00, dsf};
    for (int i = 0; i < 8; i++) id = {id, uid[8*i+:8]};
    go(iv, nil);
    go('{8'h22, 8'hC2, 8'h5A}, nil);
    go('{8'h02, 8'hC2, 8'h5A}, nil);
    tag_ready <= 1'b1;
    go(iv, id);
    go('{8'h06, 8'hC1, 8'h5A, 8'h00}, id);
    go('{8'h02, 8'hC2, 8'h5A}, id);
    go('{8'h27, 8'hC1, 8'h5A, 8'h00}, nil);
    for (int i = 0; i < 6; i++) begin
      sec_rlock <= (i == 5);
      go('{fl[i], 8'hC3, 8'h5A, fb[i], 8'h00, ct[i]}, '{8'h01, ec[i]});
    end
    sec_rlock <= 1'b0;
    for (int o = 0; o < 2; o++) begin
      f = o ? 16'($urandom % 64) * 16'h20 : 16'($urandom % 2048);
      e = '{8'h00};
      for (int k = 0; k <= (o ? 31 : 0); k++) begin
        b = f + 16'(k);
        if (o) e = {e, sec_status & 8'h1F};
        e = {e, ~b[7:0], ~b[15:8], b[7:0], b[15:8]};
      end
      go('{o ? 8'h4A : 8'h0A, 8'hC3, 8'h5A, f[7:0], f[15:8], o ? 8'h1F : 8'h00}, e);
    end
    rf_power_off <= 1'b1;
    @(posedge mclk) rf_power_off <= 1'b0;
    go(iv, nil);
    rd(8'h14, 32'h1500);
    wr(8'h00, 32'h0);
    go('{8'h02, 8'hC2, 8'h5A}, id);
    summarize();
  end
endmodule : test_rf_fast_command_handler
